//--- irda_sir_pulse_codec_test.sv
// Purpose: Self-checking bench for the infrared pulse codec
// Assumes: 40 MHz clock, transceiver model on the pins
// Notes:   Expected pulses queued by the driver, checked on report
`timescale 1ns/100ps
module irda_sir_pulse_codec_test;
    import irsir_pkg::*;

    typedef struct packed {int w; int g;} irsir_exp_t;

    logic       mclk_in  = 1'b0;
    logic       rst_in   = 1'b1;
    logic       en       = 1'b0;
    logic [1:0] cfg      = 2'b10;
    logic [5:0] div      = DIV_115;
    logic       tx_bit   = 1'b0;
    logic       tx_valid = 1'b0;
    logic       saw_full = 1'b0;
    wire logic  tx_ready;
    wire logic  rx_bit;
    wire logic  rx_zero;
    wire logic  ir_rx;
    wire logic  ir_tx;
    wire logic  done;
    int         width;
    int         gap;
    int         n_mismatch = 0;
    int         compares   = 0;
    int         cyc        = 0;
    int         nz         = 0;
    int         run        = 0;
    int         n0;
    integer     seed       = 32'hd287c14a;
    irsir_exp_t exp_q[$];
    irsir_exp_t e_cur;

    always #12.5 mclk_in = ~mclk_in;

    irsir_codec u_dut
    (
        .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(1'b1),
        .cfg_in(cfg), .baud_div_in(div), .tx_bit_in(tx_bit),
        .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
        .rx_bit_out(rx_bit), .rx_zero_out(rx_zero),
        .ir_receive_input(ir_rx), .ir_transmit_output(ir_tx)
    );

    irsir_xcvr_model u_xcvr
    (
        .mclk_in(mclk_in), .rst_in(rst_in), .en_in(en),
        .tx_low_in(cfg[1]), .rx_low_in(cfg[0]), .tx_pin_in(ir_tx),
        .rx_pin_out(ir_rx), .done_out(done), .width_out(width),
        .gap_out(gap)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Ready lags one cycle: read it settled, one idle edge before writing
    task automatic put_bit(input logic b);
        int w;
        @(posedge mclk_in);
        #2;
        while (tx_ready !== 1'b1)
        begin
            @(posedge mclk_in);
            #2;
        end
        tx_bit = b;
        tx_valid = 1'b1;
        @(posedge mclk_in);
        #2 tx_valid = 1'b0;
        w = (div == DIV_115) ? PW115_CYC :
            (div == DIV_9600) ? PW9600_CYC : PW2400_CYC;
        if (!b)
        begin
            exp_q.push_back('{w, run * BIT115_CYC * int'(div)});
            run = 1;
        end
        else if (run > 0)
            run++;
    endtask

    task automatic drain;
        wait (exp_q.size() == 0);
        repeat (BIT115_CYC * int'(div)) @(posedge mclk_in);
        run = 0;
    endtask

    ////////////////////////////////////////////////////////////////////
    always @(posedge mclk_in)
    begin
        cyc++;
        if (rx_zero === 1'b1)
        begin
            nz++;
            chk(rx_bit, 1'b0);
        end
        // Ready is low for one edge after reset, so only count it once busy
        if (en === 1'b1 && tx_ready === 1'b0)
            saw_full <= 1'b1;
        if (done === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(32'h1, 32'h0);
            else
            begin
                e_cur = exp_q.pop_front();
                chk(width, e_cur.w);
                if (e_cur.g != 0)
                    chk(gap, e_cur.g);
            end
        end
        if (cyc == 95000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    initial
    begin
        repeat (12) @(posedge mclk_in);
        #2 rst_in = 1'b0;
        @(posedge mclk_in);
        #2;
        chk(ir_tx, 1'b1);
        en = 1'b1;
        // Burst fills the FIFO so the writer must stall
        repeat (24) put_bit(1'($random(seed)));
        chk(saw_full, 1'b1);
        drain();
        // Active-high transmit
        #2 en = 1'b0;
        cfg[1] = 1'b0;
        repeat (4) @(posedge mclk_in);
        #2;
        chk(ir_tx, 1'b0);
        en = 1'b1;
        put_bit(1'b0);
        put_bit(1'b1);
        put_bit(1'b0);
        drain();
        #2 div = DIV_9600;
        put_bit(1'b0);
        put_bit(1'b1);
        put_bit(1'b0);
        drain();
        #2 div = DIV_2400;
        put_bit(1'b0);
        put_bit(1'b0);
        wait (exp_q.size() == 0);
        // Receive threshold under both polarities
        for (int p = 0; p < 2; p++)
        begin
            #2 cfg[0] = p[0];
            repeat (4) @(posedge mclk_in);
            n0 = nz;
            u_xcvr.send_pulse(RX_MIN_CYC - 1);
            repeat (8) @(posedge mclk_in);
            chk(nz, n0);
            u_xcvr.send_pulse(RX_MIN_CYC);
            repeat (8) @(posedge mclk_in);
            chk(nz, n0 + 1);
            chk(rx_bit, 1'b1);
        end
        complete_run();
    end
endmodule

//--- irsir_codec.sv
// Purpose: Infrared serial pulse encoder and decoder
// Assumes: 40 MHz clock; UART bits arrive over valid/ready
// Notes:   Baud chosen by a divisor of the 115200 bit time
// Operation
// - 115200 baud pulse 1.6 us, at most 2.71
// - 9600 baud pulse 19.5 us, at most 22.13
// - 2400 baud pulse 78 us, at most 88.55
// - Bit period 8.68 us scaled by baud divisor
// - Receive pulses shorter than 1.41 us ignored
// - Config bit 0: receive active low when set
// - Config bit 1: transmit active low, default set
`timescale 1ns/100ps
module irsir_codec
    import irsir_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
)
(
    // Clock, reset, enable
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    // Configuration
    input  wire logic [1:0] cfg_in,
    input  wire logic [5:0] baud_div_in,
    // UART transmit bit stream
    input  wire logic       tx_bit_in,
    input  wire logic       tx_valid_in,
    output logic            tx_ready_out,
    // UART receive bit stream
    output logic            rx_bit_out,
    output logic            rx_zero_out,
    // Optical transceiver pins
    input  wire logic       ir_receive_input,
    output logic            ir_transmit_output
);
    ////////////////////////////////////////////////////////////////////
    irsir_cfg_t      cfg_ff;
    irsir_tx_state_t state_ff;
    logic [CNT_W-1:0] bit_cnt_ff;
    logic [CNT_W-1:0] pw_cnt_ff;
    logic [CNT_W-1:0] bit_len;
    logic [CNT_W-1:0] pw_len;
    logic            pulse_ff;
    logic            f_bit;
    logic            f_valid;
    logic            f_take;
    logic            rdy_ff;
    logic            wready;
    logic            rx_ff;
    logic [CNT_W-1:0] rx_cnt_ff;
    logic            rx_zero_ff;
    logic            rx_bit_ff;

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            cfg_ff.rx_active_low <= RX_INV_RST;
            cfg_ff.tx_active_low <= TX_INV_RST;
        end
        else if (ce_in)
        begin
            cfg_ff.rx_active_low <= cfg_in[0];
            cfg_ff.tx_active_low <= cfg_in[1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    irsir_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk_in     (mclk_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .wdata_in   (tx_bit_in),
        .wvalid_in  (tx_valid_in),
        .wready_out (wready),
        .rdata_out  (f_bit),
        .rvalid_out (f_valid),
        .rready_in  (f_take)
    );

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            rdy_ff <= 1'b0;
        end
        else if (ce_in)
        begin
            rdy_ff <= wready;
        end
    end
    assign tx_ready_out = rdy_ff;

    // Bit length from divisor; pulse width fixed per named rate
    assign bit_len = CNT_W'(BIT115_CYC * baud_div_in);
    always_comb
    begin
        pw_len = CNT_W'(PW115_CYC * baud_div_in / 16); // default only, every branch below sets pw_len
        if (baud_div_in == DIV_115)
        begin
            pw_len = CNT_W'(PW115_CYC);
        end
        else if (baud_div_in == DIV_9600)
        begin
            pw_len = CNT_W'(PW9600_CYC);
        end
        else if (baud_div_in == DIV_2400)
        begin
            pw_len = CNT_W'(PW2400_CYC);
        end
        else
        begin
            pw_len = CNT_W'(((BIT115_CYC * 3) / 16) * baud_div_in);
        end
    end

    assign f_take = (state_ff == IRSIR_TX_IDLE) && f_valid;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            state_ff   <= IRSIR_TX_IDLE;
            bit_cnt_ff <= '0;
            pw_cnt_ff  <= '0;
            pulse_ff   <= 1'b0;
        end
        else if (ce_in)
        begin
            case (state_ff)
                IRSIR_TX_IDLE:
                begin
                    pulse_ff <= 1'b0;
                    if (f_valid)
                    begin
                        state_ff   <= IRSIR_TX_PULSE;
                        bit_cnt_ff <= bit_len - 1'b1;
                        pw_cnt_ff  <= pw_len;
                        pulse_ff   <= ~f_bit;
                    end
                end
                IRSIR_TX_PULSE:
                begin
                    if (pw_cnt_ff != '0)
                    begin
                        pw_cnt_ff <= pw_cnt_ff - 1'b1;
                    end
                    if (pw_cnt_ff <= 1)
                    begin
                        pulse_ff <= 1'b0;
                    end
                    if (bit_cnt_ff <= 1)
                    begin
                        state_ff <= IRSIR_TX_IDLE;
                    end
                    else
                    begin
                        bit_cnt_ff <= bit_cnt_ff - 1'b1;
                    end
                end
                default:
                begin
                    state_ff <= IRSIR_TX_IDLE;
                end
            endcase
        end
    end

    // Idle pin level follows polarity
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            ir_transmit_output <= TX_INV_RST;
        end
        else if (ce_in)
        begin
            ir_transmit_output <= pulse_ff
                                  ^ cfg_ff.tx_active_low;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Width filter rejects glitches below the least width
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            rx_ff      <= 1'b0;
            rx_cnt_ff  <= '0;
            rx_zero_ff <= 1'b0;
            rx_bit_ff  <= 1'b1;
        end
        else if (ce_in)
        begin
            rx_ff      <= ir_receive_input
                          ^ cfg_ff.rx_active_low;
            rx_zero_ff <= 1'b0;
            if (rx_ff)
            begin
                if (rx_cnt_ff != CNT_W'(RX_MIN_CYC))
                begin
                    rx_cnt_ff <= rx_cnt_ff + 1'b1;
                end
                if (rx_cnt_ff == CNT_W'(RX_MIN_CYC - 1))
                begin
                    rx_zero_ff <= 1'b1;
                    rx_bit_ff  <= 1'b0;
                end
            end
            else
            begin
                rx_cnt_ff <= '0;
                rx_bit_ff <= 1'b1;
            end
        end
    end
    assign rx_bit_out  = rx_bit_ff;
    assign rx_zero_out = rx_zero_ff;

    ////////////////////////////////////////////////////////////////////
    // Checked at load: odd divisors may legally run longer pulses
    property p_pw_max;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && f_take && baud_div_in == DIV_2400)
            |=> (pw_cnt_ff == CNT_W'(PW2400_CYC))
                && (PW2400_CYC <= PW2400_MAXC);
    endproperty
    a_pw_max: assert property (p_pw_max)
        else $error("Wrong pulse width at 2400");

    property p_one_no_pulse;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && f_take && f_bit) |=> !pulse_ff;
    endproperty
    a_one_no_pulse: assert property (p_one_no_pulse)
        else $error("Pulse emitted for a one bit");

    property p_zero_pulse;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && f_take && !f_bit) |=> pulse_ff;
    endproperty
    a_zero_pulse: assert property (p_zero_pulse)
        else $error("No pulse for a zero bit");

    property p_tx_pol;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && !pulse_ff)
            |=> (ir_transmit_output == $past(cfg_ff.tx_active_low));
    endproperty
    a_tx_pol: assert property (p_tx_pol)
        else $error("Idle transmit level wrong");

    property p_rx_short;
        @(posedge mclk_in) disable iff (rst_in)
        (rx_zero_ff) |-> (rx_cnt_ff >= CNT_W'(RX_MIN_CYC));
    endproperty
    a_rx_short: assert property (p_rx_short)
        else $error("Short receive pulse accepted");

    property p_rx_pol;
        @(posedge mclk_in) disable iff (rst_in)
        ce_in |=> (rx_ff == ($past(ir_receive_input)
                             ^ $past(cfg_ff.rx_active_low)));
    endproperty
    a_rx_pol: assert property (p_rx_pol)
        else $error("Receive polarity wrong");

    property p_115;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && f_take && baud_div_in == DIV_115)
            |=> (pw_cnt_ff == CNT_W'(PW115_CYC)) && (PW115_CYC <= PW115_MAXC);
    endproperty
    a_115: assert property (p_115)
        else $error("Wrong pulse width at 115200");

    property p_9600;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && f_take && baud_div_in == DIV_9600)
            |=> (pw_cnt_ff == CNT_W'(PW9600_CYC))
                && (PW9600_CYC <= PW9600_MAXC);
    endproperty
    a_9600: assert property (p_9600)
        else $error("Wrong pulse width at 9600");

    property p_bit;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && f_take) |=> (bit_cnt_ff == $past(bit_len) - 1'b1);
    endproperty
    a_bit: assert property (p_bit)
        else $error("Bit period load wrong");
endmodule

//--- irsir_fifo.sv
// Purpose: Bit FIFO between UART stream and pulse encoder
// Assumes: Single clock, synchronous reset
// Notes:   Width and depth are parameters
`timescale 1ns/100ps
module irsir_fifo
#(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
)
(
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    // Write side
    input  wire logic [WIDTH-1:0] wdata_in,
    input  wire logic             wvalid_in,
    output logic                  wready_out,
    // Read side
    output logic      [WIDTH-1:0] rdata_out,
    output logic                  rvalid_out,
    input  wire logic             rready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wptr_ff;
    logic [AW-1:0]    rptr_ff;
    logic [AW:0]      count_ff;
    logic             do_wr;
    logic             do_rd;

    assign wready_out = (count_ff != (AW+1)'(DEPTH));
    assign rvalid_out = (count_ff != '0);
    assign rdata_out  = mem_ff[rptr_ff];
    assign do_wr      = ce_in && wvalid_in && wready_out;
    assign do_rd      = ce_in && rvalid_out && rready_in;

    always_ff @(posedge clk_in)
    begin
        if (do_wr)
        begin
            mem_ff[wptr_ff] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wptr_ff  <= '0;
            rptr_ff  <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wptr_ff <= (wptr_ff == AW'(DEPTH-1)) ? '0 : wptr_ff + 1'b1;
            end
            if (do_rd)
            begin
                rptr_ff <= (rptr_ff == AW'(DEPTH-1)) ? '0 : rptr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

//--- irsir_pkg.sv
// Purpose: Shared constants and types for the infrared pulse codec
// Assumes: 40 MHz clock, 25 ns period
// Notes:   Times in ns, cycle counts derived from them
package irsir_pkg;

    localparam int CLK_PERIOD_NS = 25;
    // Transmit pulse widths, typical and longest, per baud rate
    localparam int PW115_TYP_NS  = 1600;
    localparam int PW115_MAX_NS  = 2710;
    localparam int PW9600_TYP_NS = 19500;
    localparam int PW9600_MAX_NS = 22130;
    localparam int PW2400_TYP_NS = 78000;
    localparam int PW2400_MAX_NS = 88550;
    // Bit time at 115200 baud, scaled by divisor for slower rates
    localparam int BIT115_NS     = 8680;
    // Least received pulse width
    localparam int RX_MIN_NS     = 1410;

    localparam int PW115_CYC  = PW115_TYP_NS / CLK_PERIOD_NS;
    localparam int PW9600_CYC = PW9600_TYP_NS / CLK_PERIOD_NS;
    localparam int PW2400_CYC = PW2400_TYP_NS / CLK_PERIOD_NS;
    localparam int PW115_MAXC  = PW115_MAX_NS / CLK_PERIOD_NS;
    localparam int PW9600_MAXC = PW9600_MAX_NS / CLK_PERIOD_NS;
    localparam int PW2400_MAXC = PW2400_MAX_NS / CLK_PERIOD_NS;
    localparam int BIT115_CYC = BIT115_NS / CLK_PERIOD_NS;
    localparam int RX_MIN_CYC = (RX_MIN_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;

    // Baud divisors relative to 115200
    localparam logic [5:0] DIV_115  = 6'h01;
    localparam logic [5:0] DIV_9600 = 6'h0c;
    localparam logic [5:0] DIV_2400 = 6'h30;

    // Reset values of configuration bits
    localparam logic RX_INV_RST = 1'b0;
    localparam logic TX_INV_RST = 1'b1;

    localparam int CNT_W = 16;

    typedef enum logic [1:0]
    {
        IRSIR_TX_IDLE  = 2'b01,
        IRSIR_TX_PULSE = 2'b10
    } irsir_tx_state_t;

    typedef struct packed
    {
        logic       rx_active_low;
        logic       tx_active_low;
    } irsir_cfg_t;

endpackage

//--- irsir_xcvr_model.sv
// Purpose: Optical transceiver stand-in for the pulse codec
// Assumes: Sampled on mclk_in; bench drives receive pulses
// Notes:   Reports each transmit pulse width and start spacing
`timescale 1ns/100ps
module irsir_xcvr_model
    import irsir_pkg::*;
(
    // Clock and control
    input  wire logic mclk_in,
    input  wire logic rst_in,
    input  wire logic en_in,
    input  wire logic tx_low_in,
    input  wire logic rx_low_in,
    // Pins
    input  wire logic tx_pin_in,
    output logic      rx_pin_out,
    // Measurement
    output logic      done_out,
    output int        width_out,
    output int        gap_out
);
    logic pulse_on = 1'b0;
    logic act;
    int   cnt;
    int   since;

    // Optical output is never floating: idle is the inactive level
    assign rx_pin_out = pulse_on ^ rx_low_in;
    assign act        = tx_pin_in ^ tx_low_in;

    always @(posedge mclk_in)
    begin
        done_out <= 1'b0;
        // Muted while polarity changes, else a false edge is seen
        if (rst_in || !en_in)
        begin
            cnt   <= 0;
            since <= 0;
        end
        else
        begin
            since <= since + 1;
            if (act)
                cnt <= cnt + 1;
            else if (cnt != 0)
            begin
                done_out  <= 1'b1;
                width_out <= cnt;
                cnt       <= 0;
            end
            if (act && cnt == 0)
            begin
                gap_out <= since;
                since   <= 1;
            end
        end
    end

    task automatic send_pulse(input int w);
        @(posedge mclk_in);
        #2 pulse_on = 1'b1;
        repeat (w) @(posedge mclk_in);
        #2 pulse_on = 1'b0;
    endtask
endmodule
